// *** rtl/apw_top.sv ***
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module apw_top
   import apw_pkg::*;
#(
   parameter int unsigned RES_BITS = APW_RES_BITS
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core
   input wire logic conv_start,
   input wire logic result_valid,
   input wire logic [RES_BITS-1:0] result_code,
   input wire logic [APW_STAT_BITS-1:0] sequencer_status_word,
   // host strobes and data lines
   input wire logic cs_n,
   input wire logic rd_n,
   output logic [RES_BITS+3:0] data_out,
   output logic [RES_BITS+3:0] data_oe,
   // analog front end controls
   output logic [APW_CHANNELS-1:0] mux_pos_en,
   output logic [APW_CHANNELS:0] mux_neg_en,
   output logic gain_select,
   output logic polarity_select
);

   localparam int unsigned WORD_W = RES_BITS + APW_TAG_BITS;
   localparam int unsigned LOW_W = WORD_W - APW_STAT_BITS;
   localparam logic [RES_BITS-1:0] MSB_MASK = {1'b1, {(RES_BITS-1){1'b0}}};

   default clocking apw_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // apb register access
   logic [APW_CFG_W-1:0] cfg_ff;
   logic [WORD_W-1:0] word_ff;
   apw_conv_state_t state_ff;
   logic [31:0] nxt_prdata;
   logic nxt_slverr;
   logic setup;
   logic wr_cfg;

   assign setup = psel && !penable;
   assign wr_cfg = psel && penable && pready && pwrite && (paddr == APW_CFG_OFS);

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_slverr = 1'b0;
      case (paddr)
         APW_CFG_OFS: nxt_prdata[APW_CFG_W-1:0] = cfg_ff;
         APW_RESULT_OFS: nxt_prdata[WORD_W-1:0] = word_ff;
         APW_STATUS_OFS: begin
            nxt_prdata[APW_ST_BUSY_BIT] = (state_ff == APW_CONV);
            nxt_prdata[APW_ST_DRIVE_BIT] = |data_oe;
            nxt_prdata[APW_ST_RDBK_BIT] = cfg_ff[APW_CFG_RDBK_BIT];
         end
         default: nxt_slverr = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= setup;
         if (setup) begin
            prdata <= nxt_prdata;
            pslverr <= nxt_slverr;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= APW_CFG_RST;
      end else if (clk_en && wr_cfg) begin
         cfg_ff <= pwdata[APW_CFG_W-1:0];
      end
   end

   cfg_write_a: assert property (clk_en && wr_cfg |=> cfg_ff == $past(pwdata[APW_CFG_W-1:0]))
      else $error("configuration write not stored");

   // ==========================================================
   // conversion tracking and tag capture
   logic [APW_TAG_BITS-1:0] conv_tag_ff;
   logic conv_pol_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= APW_IDLE;
      end else if (clk_en) begin
         case (state_ff)
            APW_IDLE: if (conv_start) state_ff <= APW_CONV;
            APW_CONV: if (result_valid) state_ff <= APW_IDLE;
            default: state_ff <= APW_IDLE;
         endcase
      end
   end

   // config is frozen at conversion start so the tag names that sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_tag_ff <= '0;
         conv_pol_ff <= 1'b0;
      end else if (clk_en && state_ff == APW_IDLE && conv_start) begin
         conv_tag_ff <= cfg_ff[APW_CFG_DIFFERENTIAL_MODE_BIT:0];
         conv_pol_ff <= cfg_ff[APW_CFG_POL_BIT];
      end
   end

   sequence apw_conv_begin_s;
      clk_en && state_ff == APW_IDLE && conv_start;
   endsequence

   sequence apw_conv_end_s;
      clk_en && state_ff == APW_CONV && result_valid;
   endsequence

   tag_capture_a: assert property (apw_conv_begin_s |=> conv_tag_ff == $past(cfg_ff[3:0]))
      else $error("tag not captured at conversion start");
   tag_hold_a: assert property (clk_en && state_ff == APW_CONV && !result_valid
      |=> $stable(conv_tag_ff))
      else $error("tag changed during conversion");

   // ==========================================================
   // result coding
   apw_code_if #(.RES_BITS(RES_BITS)) code_if ();

   assign code_if.raw = result_code;
   assign code_if.polarity = conv_pol_ff;
   assign code_if.tag = conv_tag_ff;

   apw_coder #(.RES_BITS(RES_BITS)) u_coder (
      .cif(code_if.cdr)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= '0;
      end else if (clk_en && state_ff == APW_CONV && result_valid) begin
         word_ff <= code_if.word;
      end
   end

   word_tag_a: assert property (apw_conv_end_s
      |=> word_ff[WORD_W-1:RES_BITS] == $past(conv_tag_ff))
      else $error("word tag differs from conversion config");
   unipolar_code_a: assert property (apw_conv_end_s ##0 !conv_pol_ff
      |=> word_ff[RES_BITS-1:0] == $past(result_code))
      else $error("unipolar result not straight binary");
   bipolar_code_a: assert property (apw_conv_end_s ##0 conv_pol_ff
      |=> word_ff[RES_BITS-1:0] == ($past(result_code) ^ MSB_MASK))
      else $error("bipolar result not two's complement");

   // ==========================================================
   // host data lines
   logic [WORD_W-1:0] nxt_data;
   logic [WORD_W-1:0] nxt_oe;
   logic rd_sel;

   assign rd_sel = !cs_n && !rd_n;

   always_comb begin
      nxt_data = word_ff;
      nxt_oe = {WORD_W{rd_sel}};
      if (cfg_ff[APW_CFG_RDBK_BIT]) begin
         nxt_data = '0;
         nxt_data[WORD_W-1:LOW_W] = sequencer_status_word;
         nxt_oe = '0;
         nxt_oe[WORD_W-1:LOW_W] = {APW_STAT_BITS{rd_sel}};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= '0;
         data_oe <= '0;
      end else if (clk_en) begin
         data_out <= nxt_data;
         data_oe <= nxt_oe;
      end
   end

   oe_needs_sel_a: assert property (clk_en && (cs_n || rd_n) |=> data_oe == '0)
      else $error("bus driven without select and read");
   drive_on_read_a: assert property (clk_en && rd_sel && !cfg_ff[APW_CFG_RDBK_BIT]
      |=> (&data_oe) && data_out == $past(word_ff))
      else $error("result word not driven on read");
   rdbk_status_a: assert property (clk_en && rd_sel && cfg_ff[APW_CFG_RDBK_BIT]
      |=> (&data_oe[WORD_W-1:LOW_W])
      && data_out[WORD_W-1:LOW_W] == $past(sequencer_status_word))
      else $error("status word not driven in readback");
   rdbk_low_z_a: assert property (clk_en && cfg_ff[APW_CFG_RDBK_BIT]
      |=> data_oe[LOW_W-1:0] == '0)
      else $error("lower lines driven during readback");

   // ==========================================================
   // multiplexer and span controls
   logic [APW_CHANNELS-1:0] nxt_pos;
   logic [APW_CHANNELS:0] nxt_neg;
   logic [2:0] ch;
   logic differential_mode;

   assign ch = cfg_ff[APW_CFG_CH_MSB:APW_CFG_CH_LSB];
   assign differential_mode = cfg_ff[APW_CFG_DIFFERENTIAL_MODE_BIT];
   assign nxt_neg[APW_CHANNELS] = !differential_mode;

   // single ended: channel against common; differential: pair, ch[0] picks polarity
   for (genvar i = 0; i < APW_CHANNELS; i++) begin : g_mux
      localparam logic [2:0] IDX = 3'(i);
      assign nxt_pos[i] = differential_mode ? (ch == IDX) : (ch == IDX);
      assign nxt_neg[i] = differential_mode && (ch[2:1] == IDX[2:1]) && (ch[0] != IDX[0]);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_pos_en <= '0;
         mux_neg_en <= '0;
      end else if (clk_en) begin
         mux_pos_en <= nxt_pos;
         mux_neg_en <= nxt_neg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_select <= APW_CFG_RST[APW_CFG_GAIN_BIT];
         polarity_select <= APW_CFG_RST[APW_CFG_POL_BIT];
      end else if (clk_en) begin
         gain_select <= cfg_ff[APW_CFG_GAIN_BIT];
         polarity_select <= cfg_ff[APW_CFG_POL_BIT];
      end
   end

   // rst_n in the antecedent keeps the edge that still holds reset out of the check
   mux_single_a: assert property (rst_n && clk_en && !differential_mode
      |=> mux_neg_en == 9'h100 && mux_pos_en == (8'h01 << $past(ch)))
      else $error("single ended selection wrong");
   mux_differential_mode_a: assert property (rst_n && clk_en && differential_mode
      |=> mux_pos_en == (8'h01 << $past(ch)) && mux_neg_en == (9'h001 << ($past(ch) ^ 3'h1)))
      else $error("differential pair selection wrong");
   gain_pin_a: assert property (clk_en |=> gain_select == $past(cfg_ff[APW_CFG_GAIN_BIT]))
      else $error("gain select not following configuration");

endmodule

// *** common/apw_pkg.sv ***
package apw_pkg;

   // ==========================================================
   // word geometry
   localparam int unsigned APW_RES_BITS = 12;
   localparam int unsigned APW_TAG_BITS = 4;
   localparam int unsigned APW_STAT_BITS = 7;
   localparam int unsigned APW_CHANNELS = 8;

   // ==========================================================
   // register offsets
   localparam logic [7:0] APW_CFG_OFS = 8'h00;
   localparam logic [7:0] APW_RESULT_OFS = 8'h04;
   localparam logic [7:0] APW_STATUS_OFS = 8'h08;

   // ==========================================================
   // configuration field positions and reset value
   localparam int unsigned APW_CFG_CH_LSB = 0;
   localparam int unsigned APW_CFG_CH_MSB = 2;
   localparam int unsigned APW_CFG_DIFFERENTIAL_MODE_BIT = 3;
   localparam int unsigned APW_CFG_POL_BIT = 4;
   localparam int unsigned APW_CFG_GAIN_BIT = 5;
   localparam int unsigned APW_CFG_RDBK_BIT = 6;
   localparam int unsigned APW_CFG_W = 7;
   localparam logic [6:0] APW_CFG_RST = 7'h20;

   // ==========================================================
   // status field positions
   localparam int unsigned APW_ST_BUSY_BIT = 0;
   localparam int unsigned APW_ST_DRIVE_BIT = 1;
   localparam int unsigned APW_ST_RDBK_BIT = 2;

   // ==========================================================
   // conversion tracking
   typedef enum logic [0:0] {
      APW_IDLE = 1'b0,
      APW_CONV = 1'b1
   } apw_conv_state_t;

endpackage

// *** common/apw_code_if.sv ***
`timescale 1ns/1ps
interface apw_code_if #(parameter int unsigned RES_BITS = 12);
   logic [RES_BITS-1:0] raw;
   logic polarity;
   logic [3:0] tag;
   logic [RES_BITS+3:0] word;
   modport src (output raw, output polarity, output tag, input word);
   modport cdr (input raw, input polarity, input tag, output word);
endinterface

// *** rtl/apw_coder.sv ***
`timescale 1ns/1ps
module apw_coder
   import apw_pkg::*;
#(
   parameter int unsigned RES_BITS = APW_RES_BITS
) (
   // raw offset code in, tagged output word out
   apw_code_if.cdr cif
);

   // ==========================================================
   // coding: offset code straight through, or msb flipped
   logic [RES_BITS-1:0] coded;

   always_comb begin
      coded = cif.raw;
      if (cif.polarity) begin
         coded[RES_BITS-1] = ~cif.raw[RES_BITS-1];
      end
      cif.word = {cif.tag, coded};
   end

endmodule

// *** bench/apw_host_model.sv ***
`timescale 1ns/1ps
module apw_host_model #(
   parameter int unsigned W = 16
) (
   // clock
   input wire logic clk,
   // strobes
   output logic cs_n,
   output logic rd_n,
   // data lines
   input wire logic [W-1:0] data_out,
   input wire logic [W-1:0] data_oe
);
   logic [W-1:0] last_ff = '0;
   logic [W-1:0] bus;
   // undriven lines show the inverse of their last level
   assign bus = (data_oe & data_out) | (~data_oe & ~last_ff);
   always_ff @(posedge clk) begin
      last_ff <= bus;
   end
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
   end
   task automatic read_bus(input logic sel_n, output logic [W-1:0] val, output logic [W-1:0] oe);
      @(posedge clk);
      cs_n <= sel_n;
      rd_n <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      val = bus;
      oe = data_oe;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask
endmodule

// *** bench/adc_parallel_output_word_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end end
module adc_parallel_output_word_tb;
   import apw_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, conv_start, result_valid, er;
   logic gain_select, polarity_select, cs_n, rd_n;
   logic [7:0] paddr, mux_pos_en;
   logic [8:0] mux_neg_en;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] result_code;
   logic [6:0] stat_word;
   logic [15:0] data_out, data_oe, val, oe;
   int err_total = 0;
   int cmp_count = 0;
   apw_top apw_top_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_start(conv_start), .result_valid(result_valid),
      .result_code(result_code), .sequencer_status_word(stat_word), .cs_n(cs_n), .rd_n(rd_n),
      .data_out(data_out), .data_oe(data_oe), .mux_pos_en(mux_pos_en),
      .mux_neg_en(mux_neg_en), .gain_select(gain_select), .polarity_select(polarity_select));
   apw_host_model apw_host_model_inst (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
      .data_out(data_out), .data_oe(data_oe));
   // ==========================================
   // bus tasks
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // values read here are those that stood at this rising edge
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n >= 20) begin
         err_total++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse_start();
      @(posedge clk);
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
   endtask
   task automatic finish_result(input logic [11:0] code);
      @(posedge clk);
      result_valid <= 1'b1;
      result_code <= code;
      @(posedge clk);
      result_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs();
      apb(1'b0, APW_CFG_OFS, 32'h0);
      `CHK(rd, 32'h00000020)
      `CHK(gain_select, 1'b1)
      apb(1'b1, APW_CFG_OFS, 32'h00000005);
      repeat (2) @(negedge clk);
      `CHK({mux_pos_en, mux_neg_en}, {8'h20, 9'h100})
      `CHK({gain_select, polarity_select}, 2'b00)
      apb(1'b1, APW_CFG_OFS, 32'h0000000B);
      repeat (2) @(negedge clk);
      `CHK({mux_pos_en, mux_neg_en}, {8'h08, 9'h004})
      apb(1'b0, 8'h10, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
   endtask
   task automatic t_uni();
      apb(1'b1, APW_CFG_OFS, 32'h00000025);
      pulse_start();
      apb(1'b0, APW_STATUS_OFS, 32'h0);
      `CHK(rd[0], 1'b1)
      apb(1'b1, APW_CFG_OFS, 32'h0000003A);
      finish_result(12'hABC);
      apw_host_model_inst.read_bus(1'b0, val, oe);
      `CHK({oe, val}, {16'hFFFF, 16'h5ABC})
      apb(1'b0, APW_RESULT_OFS, 32'h0);
      `CHK(rd[15:0], 16'h5ABC)
   endtask
   task automatic t_bip();
      pulse_start();
      finish_result(12'h7FF);
      `CHK(polarity_select, 1'b1)
      apw_host_model_inst.read_bus(1'b0, val, oe);
      `CHK({oe, val}, {16'hFFFF, 16'hAFFF})
      apw_host_model_inst.read_bus(1'b1, val, oe);
      `CHK(oe, 16'h0000)
   endtask
   task automatic t_rdbk();
      stat_word <= 7'h5A;
      apb(1'b1, APW_CFG_OFS, 32'h00000060);
      apw_host_model_inst.read_bus(1'b0, val, oe);
      `CHK(oe, 16'hFE00)
      `CHK(val[15:9], 7'h5A)
      apw_host_model_inst.read_bus(1'b1, val, oe);
      `CHK(oe, 16'h0000)
      apb(1'b0, APW_STATUS_OFS, 32'h0);
      `CHK({er, rd[2:0]}, 4'b0100)
   endtask
   task automatic finish_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200us;
      err_total++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_start = 1'b0;
      result_valid = 1'b0;
      result_code = 12'h000;
      stat_word = 7'h00;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_uni();
      t_bip();
      t_rdbk();
      finish_test();
   end
endmodule
